// >>> rtl/clnb_top.sv
// character display controller seen from its nibble host bus
`timescale 1ns/1ns
module clnb_top
	import clnb_pkg::*;
#(
	parameter int EXEC_CYCLES = EXEC_CYC,
	parameter int DEPTH       = FIFO_DEPTH
) (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       transfer_strobe_i,
	input  wire logic       register_select_line_i,
	input  wire logic       direction_line_i,
	input  wire logic [3:0] shared_flash_data_lines_i,
	output logic [3:0]      shared_flash_data_lines_o,
	output logic            shared_flash_data_lines_oe_o,
	output logic            busy_indicator_o,
	output logic [2:0]      disp_ctl_o,
	input  wire logic       scan_row_i,
	input  wire logic [3:0] scan_col_i,
	input  wire logic [2:0] scan_line_i,
	output logic [7:0]      scan_code_o,
	output logic            scan_custom_o,
	output logic [4:0]      scan_dots_o
);
	localparam int DW = $clog2(EXEC_CYCLES + 1);
	localparam int EW = $bits(clnb_entry_t);

	// ==========================================================
	// reset release through two flops
	logic rst_s1_r;
	logic rst_n;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// ==========================================================
	// helpers for the row-wise address counter
	function automatic logic dd_valid(input logic [6:0] a);
		dd_valid = a[5:0] <= DD_COL_LAST;
	endfunction : dd_valid

	function automatic logic [6:0] dd_idx(input logic [6:0] a);
		dd_idx = a[6] ? 7'(a[5:0]) + DD_ROW2_OFS : 7'(a[5:0]);
	endfunction : dd_idx

	// rows wrap into each other at their fortieth column
	function automatic logic [6:0] step(input logic [6:0] a,
		input logic up, input logic cg);
		if (cg)
			step = {a[6], up ? a[5:0] + 1'b1 : a[5:0] - 1'b1};
		else if (up && a[5:0] == DD_COL_LAST)
			step = {~a[6], DD_COL_FIRST};
		else if (!up && a[5:0] == DD_COL_FIRST)
			step = {~a[6], DD_COL_LAST};
		else
			step = up ? a + 1'b1 : a - 1'b1;
	endfunction : step

	function automatic logic lead_is(input logic [7:0] v, input int k);
		lead_is = (v >> k) == 8'h01;
	endfunction : lead_is

	// ==========================================================
	// host bus front end
	logic       strobe_q_r;
	logic       cap_rs_r;
	logic       cap_rw_r;
	logic [3:0] cap_d_r;
	logic       phase_r;
	logic [3:0] upper_r;
	logic       fall;
	logic       done_wr;
	logic       done_rd_lo;
	logic       push;

	// a transfer completes on the falling edge of the strobe
	assign fall       = strobe_q_r && !transfer_strobe_i;
	assign done_wr    = fall && !cap_rw_r;
	assign done_rd_lo = fall && cap_rw_r && phase_r;
	assign push       = done_wr && phase_r;

	// inputs are only looked at while the strobe is high
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q_r <= 1'b0;
			cap_rs_r   <= 1'b0;
			cap_rw_r   <= 1'b0;
			cap_d_r    <= '0;
		end else begin
			strobe_q_r <= transfer_strobe_i;
			if (transfer_strobe_i) begin
				cap_rs_r <= register_select_line_i;
				cap_rw_r <= direction_line_i;
				cap_d_r  <= shared_flash_data_lines_i;
			end
		end
	end

	// nibble pairing, upper nibble comes first
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 1'b0;
			upper_r <= '0;
		end else begin
			if (fall) phase_r <= !phase_r;
			if (done_wr && !phase_r) upper_r <= cap_d_r;
		end
	end

	// ==========================================================
	// write fifo, a full fifo shows as busy to the host
	clnb_entry_t wr_ent;
	clnb_entry_t ent;
	logic [EW-1:0] fifo_rdata;
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic          pop;

	assign wr_ent = '{rs: cap_rs_r, val: {upper_r, cap_d_r}};
	assign ent    = clnb_entry_t'(fifo_rdata);

	clnb_fifo #(
		.W     (EW),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_i       (core_clk_i),
		.rst_ni      (rst_n),
		.in_valid_i  (push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (wr_ent),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_rdata)
	);

	// ==========================================================
	// execution pacing divider
	logic [DW-1:0] div_r;
	logic          tick;

	assign tick = div_r == DW'(EXEC_CYCLES - 1);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) div_r <= '0;
		else        div_r <= tick ? '0 : div_r + 1'b1;
	end

	// ==========================================================
	// executor decode
	clnb_state_t st_r;
	clnb_state_t st_nxt;
	logic [6:0]  clr_idx_r;
	logic [6:0]  ac_r;
	logic [6:0]  ac_nxt;
	logic        tgt_cg_r;
	logic        tgt_cg_nxt;
	logic        id_r;
	logic        id_nxt;
	logic [2:0]  disp_r;
	logic [2:0]  disp_nxt;
	logic        is_data;
	logic        is_cmd;
	logic        c_dd;
	logic        c_cg;
	logic        c_shift;
	logic        c_disp;
	logic        c_entry;
	logic        c_home;
	logic        c_clear;
	logic        busy_w;

	assign pop     = tick && fifo_out_valid && st_r == ST_IDLE;
	assign is_data = pop && ent.rs;
	assign is_cmd  = pop && !ent.rs;
	assign c_dd    = is_cmd && ent.val[CMD_DD];
	assign c_cg    = is_cmd && lead_is(ent.val, CMD_CG);
	assign c_shift = is_cmd && lead_is(ent.val, CMD_SHIFT);
	assign c_disp  = is_cmd && lead_is(ent.val, CMD_DISP);
	assign c_entry = is_cmd && lead_is(ent.val, CMD_ENTRY);
	assign c_home  = is_cmd && lead_is(ent.val, CMD_HOME);
	assign c_clear = is_cmd && lead_is(ent.val, CMD_CLEAR);
	assign busy_w  = st_r != ST_IDLE || fifo_out_valid;

	// next control state; function set is accepted with no effect
	always_comb begin
		ac_nxt     = ac_r;
		tgt_cg_nxt = tgt_cg_r;
		id_nxt     = id_r;
		disp_nxt   = disp_r;
		if (is_data) begin
			ac_nxt = step(ac_r, id_r, tgt_cg_r);
		end else if (c_shift && !ent.val[BIT_SC]) begin
			ac_nxt = step(ac_r, ent.val[BIT_RL], tgt_cg_r);
		end else if (c_dd) begin
			ac_nxt     = ent.val[6:0];
			tgt_cg_nxt = 1'b0;
		end else if (c_cg) begin
			ac_nxt     = {1'b0, ent.val[5:0]};
			tgt_cg_nxt = 1'b1;
		end else if (c_disp) begin
			disp_nxt = ent.val[2:0];
		end else if (c_entry) begin
			id_nxt = ent.val[BIT_ID];
		end else if (c_home || c_clear) begin
			ac_nxt     = AC_RST;
			tgt_cg_nxt = 1'b0;
			if (c_clear) id_nxt = ID_RST;
		end else if (done_rd_lo && cap_rs_r) begin
			ac_nxt = step(ac_r, id_r, tgt_cg_r);
		end
	end

	// clear walks all locations once, one per cycle
	always_comb begin
		st_nxt = st_r;
		if (c_clear)
			st_nxt = ST_CLEAR;
		else if (st_r == ST_CLEAR && clr_idx_r == DD_LAST_IDX)
			st_nxt = ST_IDLE;
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= ST_IDLE;
			clr_idx_r <= '0;
			ac_r      <= AC_RST;
			tgt_cg_r  <= 1'b0;
			id_r      <= ID_RST;
			disp_r    <= DISP_RST;
		end else begin
			st_r      <= st_nxt;
			clr_idx_r <= st_r == ST_CLEAR ? clr_idx_r + 1'b1 : '0;
			ac_r      <= ac_nxt;
			tgt_cg_r  <= tgt_cg_nxt;
			id_r      <= id_nxt;
			disp_r    <= disp_nxt;
		end
	end

	// ==========================================================
	// display memory, eighty codes in two rows of forty
	logic [7:0] ddram [DD_LOCS];
	logic       dd_we;
	logic [6:0] dd_wa;
	logic [7:0] dd_wd;
	logic [6:0] scan_idx;
	logic [7:0] scan_code;
	logic [7:0] dd_rd;

	// addresses past column forty are dropped, not aliased
	assign dd_we = st_r == ST_CLEAR ||
		(is_data && !tgt_cg_r && dd_valid(ac_r));
	assign dd_wa = st_r == ST_CLEAR ? clr_idx_r : dd_idx(ac_r);
	assign dd_wd = st_r == ST_CLEAR ? BLANK_CODE : ent.val;
	assign dd_rd = dd_valid(ac_r) ? ddram[dd_idx(ac_r)] : '0;

	always_ff @(posedge core_clk_i) begin
		if (dd_we) ddram[dd_wa] <= dd_wd;
	end

	// ==========================================================
	// glyph memory and scan path
	logic [4:0] cg_host_dots;
	logic [4:0] cg_scan_dots;
	logic       scan_custom;

	// unshifted view: row two starts forty locations in
	assign scan_idx    = scan_row_i ? 7'(scan_col_i) + DD_ROW2_OFS
		: 7'(scan_col_i);
	assign scan_code   = ddram[scan_idx];
	assign scan_custom = scan_code[7:3] == CUSTOM_HI;

	clnb_glyph_ram #(
		.SLOTS (GLYPH_SLOTS),
		.ROWS  (GLYPH_ROWS),
		.W     (GLYPH_W)
	) u_glyph (
		.clk_i     (core_clk_i),
		.rst_ni    (rst_n),
		.we_i      (is_data && tgt_cg_r),
		.waddr_i   (ac_r[5:0]),
		.wdata_i   (ent.val[4:0]),
		.raddr_a_i (ac_r[5:0]),
		.rdata_a_o (cg_host_dots),
		.raddr_b_i ({scan_code[2:0], scan_line_i}),
		.rdata_b_o (cg_scan_dots)
	);

	// ==========================================================
	// read data and registered outputs
	logic [7:0] rd_word;

	assign rd_word = !register_select_line_i ? {busy_w, ac_r}
		: (tgt_cg_r ? 8'(cg_host_dots) : dd_rd);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			shared_flash_data_lines_o    <= '0;
			shared_flash_data_lines_oe_o <= 1'b0;
			busy_indicator_o             <= 1'b0;
			disp_ctl_o                   <= DISP_RST;
			scan_code_o                  <= '0;
			scan_custom_o                <= 1'b0;
			scan_dots_o                  <= '0;
		end else begin
			shared_flash_data_lines_o    <= phase_r ? rd_word[3:0]
				: rd_word[7:4];
			shared_flash_data_lines_oe_o <= transfer_strobe_i &&
				direction_line_i;
			busy_indicator_o             <= busy_w;
			disp_ctl_o                   <= disp_r;
			scan_code_o                  <= scan_code;
			scan_custom_o                <= scan_custom;
			scan_dots_o                  <= scan_custom ? cg_scan_dots : '0;
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	a_oe_read_only: assert property (
		shared_flash_data_lines_oe_o |-> $past(direction_line_i))
		else $error("data lines driven outside a read");
	a_read_drives: assert property (
		(transfer_strobe_i && direction_line_i)
		|=> shared_flash_data_lines_oe_o)
		else $error("read not presented");
	a_quiet_ignore: assert property (
		(!transfer_strobe_i && !strobe_q_r)
		|=> $stable(phase_r) && $stable(upper_r) && $stable(cap_d_r))
		else $error("bus state moved with strobe low");
	a_upper_first: assert property (
		(done_wr && !phase_r) |=> upper_r == $past(cap_d_r) && phase_r)
		else $error("byte not paired upper first");
	a_busy_nibble: assert property (
		(transfer_strobe_i && direction_line_i &&
		!register_select_line_i && !phase_r)
		|=> shared_flash_data_lines_o[3] == $past(busy_w))
		else $error("busy indicator not on top line");
	a_step_inc: assert property (
		(is_data && id_r && !tgt_cg_r && ac_r[5:0] < DD_COL_LAST)
		|=> ac_r == $past(ac_r) + 1'b1)
		else $error("counter did not increment");
	a_row_wrap: assert property (
		(is_data && id_r && !tgt_cg_r && ac_r == {1'b0, DD_COL_LAST})
		|=> ac_r[6] && ac_r[5:0] == DD_COL_FIRST)
		else $error("row one did not wrap to row two");
	a_clear_len: assert property (
		$rose(st_r == ST_CLEAR) |-> ##80 st_r == ST_IDLE)
		else $error("clear did not cover eighty locations");
	a_custom_code: assert property (
		scan_custom_o |-> scan_code_o[7:3] == CUSTOM_HI)
		else $error("custom glyph for a rom code");

	c_byte_written: cover property (push ##[1:1000] is_data);
	c_read_pair: cover property (done_rd_lo && cap_rs_r);
	c_clear_done: cover property (st_r == ST_CLEAR ##80 st_r == ST_IDLE);
	c_custom_shown: cover property (scan_custom_o && scan_dots_o != '0);

endmodule : clnb_top

// >>> rtl/clnb_pkg.sv
// shared constants and types of the character display nibble bus port
package clnb_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int EXEC_TIME_NS  = 40000;
	// least time per command, rounded up to whole cycles
	localparam int EXEC_CYC      =
		(EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// display memory layout
	localparam logic [5:0] DD_COL_FIRST = 6'h00;
	localparam logic [5:0] DD_COL_LAST  = 6'h27;
	localparam logic [6:0] DD_ROW2_OFS  = 7'h28;
	localparam logic [6:0] DD_LAST_IDX  = 7'h4f;
	localparam int         DD_LOCS      = 80;
	localparam logic [7:0] BLANK_CODE   = 8'h20;
	localparam logic [4:0] CUSTOM_HI    = 5'h00;

	// ==========================================================
	// glyph memory layout
	localparam int GLYPH_SLOTS = 8;
	localparam int GLYPH_ROWS  = 8;
	localparam int GLYPH_W     = 5;

	// ==========================================================
	// instruction leading-one positions and field bits
	localparam int CMD_DD    = 7;
	localparam int CMD_CG    = 6;
	localparam int CMD_SHIFT = 4;
	localparam int CMD_DISP  = 3;
	localparam int CMD_ENTRY = 2;
	localparam int CMD_HOME  = 1;
	localparam int CMD_CLEAR = 0;
	localparam int BIT_SC    = 3;
	localparam int BIT_RL    = 2;
	localparam int BIT_ID    = 1;

	// ==========================================================
	// reset values and sizes
	localparam logic [6:0] AC_RST     = 7'h00;
	localparam logic       ID_RST     = 1'b1;
	localparam logic [2:0] DISP_RST   = 3'h0;
	localparam int         FIFO_DEPTH = 8;

	// one written byte with its register select
	typedef struct packed {
		logic       rs;
		logic [7:0] val;
	} clnb_entry_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CLEAR = 2'b01
	} clnb_state_t;

endpackage : clnb_pkg

// >>> rtl/clnb_fifo.sv
// small valid/ready fifo for written bytes
`timescale 1ns/1ns
module clnb_fifo #(
	parameter int W     = 9,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_ni,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	logic         wr_fire;
	logic         rd_fire;

	// ==========================================================
	// flags from pointers with one wrap bit
	assign out_valid_o = wp_r != rp_r;
	assign in_ready_o  = !((wp_r[AW] != rp_r[AW]) &&
		(wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign wr_fire     = in_valid_i && in_ready_o;
	assign rd_fire     = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rp_r[AW-1:0]];

	// pointers
	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (wr_fire) wp_r <= wp_r + 1'b1;
			if (rd_fire) rp_r <= rp_r + 1'b1;
		end
	end

	// storage has no reset, only valid entries are read
	always_ff @(posedge clk_i) begin
		if (wr_fire) mem[wp_r[AW-1:0]] <= in_data_i;
	end

	a_fifo_fill: assert property (@(posedge clk_i) disable iff (!rst_ni)
		(wr_fire && !rd_fire) |=> (wp_r - rp_r) == $past(wp_r - rp_r) + 1'b1)
		else $error("fifo fill level did not grow");
	c_fifo_full: cover property (@(posedge clk_i) disable iff (!rst_ni)
		!in_ready_o);

endmodule : clnb_fifo

// >>> rtl/clnb_glyph_ram.sv
// custom glyph bitmap store, one write port and two read ports
`timescale 1ns/1ns
module clnb_glyph_ram #(
	parameter int SLOTS = 8,
	parameter int ROWS  = 8,
	parameter int W     = 5
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_ni,
	input  wire logic                          we_i,
	input  wire logic [$clog2(SLOTS*ROWS)-1:0] waddr_i,
	input  wire logic [W-1:0]                  wdata_i,
	input  wire logic [$clog2(SLOTS*ROWS)-1:0] raddr_a_i,
	output logic [W-1:0]                       rdata_a_o,
	input  wire logic [$clog2(SLOTS*ROWS)-1:0] raddr_b_i,
	output logic [W-1:0]                       rdata_b_o
);
	// upper address bits pick the slot, lower bits the row
	logic [W-1:0] mem [SLOTS*ROWS];

	always_ff @(posedge clk_i) begin
		if (we_i) mem[waddr_i] <= wdata_i;
	end

	assign rdata_a_o = mem[raddr_a_i];
	assign rdata_b_o = mem[raddr_b_i];

	a_glyph_store: assert property (@(posedge clk_i) disable iff (!rst_ni)
		we_i |=> mem[$past(waddr_i)] == $past(wdata_i))
		else $error("glyph row not stored");

endmodule : clnb_glyph_ram

// >>> tb/clnb_host_model.sv
// host logic model that drives the display nibble bus
`timescale 1ns/1ns
module clnb_host_model (
	input  wire logic       clk_i,
	output logic            strobe_o,
	output logic            rs_o,
	output logic            rw_o,
	input  wire logic [3:0] dev_d_i,
	input  wire logic       dev_oe_i,
	output logic [3:0]      d_o
);
	logic [3:0] hd_r;
	logic       hoe_r;
	logic [3:0] last_r;

	// ==========================================================
	// wire level
	// no pull on these lines, so a released bus shows a changing level
	assign d_o = dev_oe_i ? dev_d_i : (hoe_r ? hd_r : ~last_r);
	always @(posedge clk_i) last_r <= d_o;

	initial begin
		strobe_o = 1'b0;
		rs_o = 1'b0;
		rw_o = 1'b0;
		hd_r = 4'h0;
		hoe_r = 1'b0;
		last_r = 4'h0;
	end

	// ==========================================================
	// bus cycles
	// strobe high two cycles, low at least one; levels held meanwhile
	task automatic pulse(input logic rs, input logic rw,
		input logic [3:0] nib, output logic [3:0] got);
		@(posedge clk_i);
		strobe_o <= 1'b1;
		rs_o     <= rs;
		rw_o     <= rw;
		hd_r     <= nib;
		hoe_r    <= !rw;
		@(posedge clk_i);
		#1 got = d_o;
		@(posedge clk_i);
		strobe_o <= 1'b0;
	endtask : pulse

	// a whole byte, upper nibble first
	task automatic xfer(input logic rs, input logic rw,
		input logic [7:0] val, output logic [7:0] got);
		pulse(rs, rw, val[7:4], got[7:4]);
		pulse(rs, rw, val[3:0], got[3:0]);
	endtask : xfer

	// one idle cycle with random levels while the strobe stays low
	task automatic noise();
		@(posedge clk_i);
		rs_o  <= 1'($urandom);
		rw_o  <= 1'($urandom);
		hd_r  <= 4'($urandom);
		hoe_r <= 1'b0;
	endtask : noise
endmodule : clnb_host_model

// >>> tb/clnb_top_tb.sv
// self-checking bench of the character display nibble bus port
`timescale 1ns/1ns
module clnb_top_tb;
	import clnb_pkg::*;
	localparam int EXEC  = 40;
	localparam int LIMIT = 40000;
	logic       clk, rstn, strobe, rs, rw, oe, busy, row, cust;
	logic [3:0] d, dout, col;
	logic [2:0] ctl, line;
	logic [7:0] code, g;
	logic [4:0] dots;
	int         errors, checks, cyc, ac, i, r, c, v;
	int         dd[128];
	int         cg[64];
	bit         up, tcg;

	clnb_top #(.EXEC_CYCLES(EXEC), .DEPTH(FIFO_DEPTH)) i_clnb_top (
		.core_clk_i(clk), .resetn_i(rstn), .transfer_strobe_i(strobe),
		.register_select_line_i(rs), .direction_line_i(rw),
		.shared_flash_data_lines_i(d), .shared_flash_data_lines_o(dout),
		.shared_flash_data_lines_oe_o(oe), .busy_indicator_o(busy),
		.disp_ctl_o(ctl), .scan_row_i(row), .scan_col_i(col),
		.scan_line_i(line), .scan_code_o(code), .scan_custom_o(cust),
		.scan_dots_o(dots));
	clnb_host_model i_clnb_host_model (.clk_i(clk), .strobe_o(strobe),
		.rs_o(rs), .rw_o(rw), .dev_d_i(dout), .dev_oe_i(oe), .d_o(d));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			errors++;
			$display("unexpected timeout at %0t", $time);
			end_sim();
		end
	end

	// ==========================================================
	// checks
	task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected byte at %0t: %h not %h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected bit at %0t: %b not %b", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic end_sim();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// ==========================================================
	// reference model
	// row ends wrap into the other row, glyph counter wraps at six bits
	function automatic int step(int a);
		if (tcg)
			return up ? (a + 1) % 64 : (a + 63) % 64;
		if (up)
			return a == 39 ? 64 : (a == 103 ? 0 : a + 1);
		return a == 64 ? 39 : (a == 0 ? 103 : a - 1);
	endfunction : step

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000) begin
			@(posedge clk);
			#1 n++;
		end
		cmp_bit(busy, 1'b0);
	endtask : wait_idle

	// write a byte, update the model, see busy rise and fall
	task automatic wr(input logic rsel, input logic [7:0] val);
		int n;
		bit s;
		i_clnb_host_model.xfer(rsel, 1'b0, val, g);
		s = up;
		if (rsel) begin
			if (tcg) cg[ac] = int'(val[4:0]);
			else dd[ac] = int'(val);
			ac = step(ac);
		end else if (val[7]) begin
			ac = int'(val[6:0]);
			tcg = 1'b0;
		end else if (val[6]) begin
			ac = int'(val[5:0]);
			tcg = 1'b1;
		end else if (val[5]) begin
			n = 0;
		end else if (val[4]) begin
			up = val[2];
			if (!val[3]) ac = step(ac);
			up = s;
		end else if (val[3]) begin
			n = 0;
		end else if (val[2]) begin
			up = val[1];
		end else if (val[1]) begin
			ac = 0;
			tcg = 1'b0;
		end else if (val[0]) begin
			foreach (dd[k]) dd[k] = 32;
			ac = 0;
			tcg = 1'b0;
			up = 1'b1;
		end
		n = 0;
		while (busy !== 1'b1 && n < 6) begin
			@(posedge clk);
			#1 n++;
		end
		cmp_bit(busy, 1'b1);
		wait_idle();
	endtask : wr

	task automatic rd_chk(input logic rsel, input logic [7:0] exp);
		i_clnb_host_model.xfer(rsel, 1'b1, 8'h00, g);
		cmp_val(g, exp);
		if (rsel) ac = step(ac);
	endtask : rd_chk

	task automatic scan_chk(input int sr, input int sc, input int sl);
		int e;
		@(posedge clk);
		row  <= 1'(sr);
		col  <= 4'(sc);
		line <= 3'(sl);
		repeat (2) @(posedge clk);
		#1 e = dd[sr * 64 + sc];
		cmp_val(code, 8'(e));
		cmp_bit(cust, e < 8);
		cmp_val({3'b0, dots}, e < 8 ? 8'(cg[e * 8 + sl]) : 8'h00);
	endtask : scan_chk

	// ==========================================================
	// main sequence
	initial begin
		v = $urandom(32'hcab3);
		rstn = 1'b0;
		row = 1'b0;
		col = 4'h0;
		line = 3'h0;
		up = 1'b1;
		repeat (15) @(posedge clk);
		cmp_bit(oe, 1'b0);
		cmp_bit(busy, 1'b0);
		@(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		wr(1'b0, 8'h28);
		wr(1'b0, 8'h01);
		scan_chk(1, 3, 0);
		// every display on/off combination
		for (i = 0; i < 8; i++) begin
			wr(1'b0, 8'(8 | i));
			cmp_val({5'b0, ctl}, 8'(i));
		end
		wr(1'b0, 8'h06);
		// both visible rows, some codes in the custom range
		for (r = 0; r < 2; r++) begin
			wr(1'b0, 8'(128 + r * 64));
			for (c = 0; c < 16; c++)
				wr(1'b1, 8'(c % 4 == 0 ? $urandom % 8 : $urandom));
		end
		rd_chk(1'b0, 8'(ac));
		// end of first row runs into the second
		wr(1'b0, 8'ha6);
		repeat (3) wr(1'b1, 8'($urandom));
		rd_chk(1'b0, 8'(ac));
		// stepping down crosses back
		wr(1'b0, 8'h04);
		wr(1'b0, 8'hc0);
		wr(1'b1, 8'($urandom));
		rd_chk(1'b0, 8'(ac));
		wr(1'b0, 8'h06);
		wr(1'b0, 8'h85);
		rd_chk(1'b1, 8'(dd[5]));
		rd_chk(1'b0, 8'(ac));
		wr(1'b0, 8'h14);
		rd_chk(1'b0, 8'(ac));
		wr(1'b0, 8'h10);
		rd_chk(1'b0, 8'(ac));
		wr(1'b0, 8'h18); // display shift leaves the counter alone
		rd_chk(1'b0, 8'(ac));
		wr(1'b0, 8'h02);
		rd_chk(1'b0, 8'h00);
		// all glyph rows with junk in the upper bits
		wr(1'b0, 8'h40);
		for (i = 0; i < 64; i++)
			wr(1'b1, i % 8 == 7 ? 8'h00 : 8'($urandom));
		wr(1'b0, 8'h53);
		rd_chk(1'b1, 8'(cg[ac]));
		for (r = 0; r < 2; r++)
			for (c = 0; c < 16; c++)
				scan_chk(r, c, $urandom % 8);
		// levels wiggle with strobe low: nothing taken, nothing driven
		for (i = 0; i < 20; i++) begin
			i_clnb_host_model.noise();
			#1 cmp_bit(oe, 1'b0);
		end
		rd_chk(1'b0, 8'(ac));
		// burst beyond the buffer, only the first entries are sure
		wr(1'b0, 8'h80);
		for (i = 0; i < FIFO_DEPTH + 4; i++) begin
			v = $urandom % 256;
			i_clnb_host_model.xfer(1'b1, 1'b0, 8'(v), g);
			if (i < FIFO_DEPTH) dd[i] = v;
		end
		wait_idle();
		for (c = 0; c < FIFO_DEPTH; c++)
			scan_chk(0, c, 0);
		end_sim();
	end
endmodule : clnb_top_tb
